// [pss_pkg.sv]
// constants, field layouts and opcode encoding for the program sequencer
// assumes a single 100 MHz clock and an APB master reaching the register map
// Function
// (RULE1) pc advances by one unless branching
// (RULE2) eleven bit pc, only low byte addressable
// (RULE3) branch, call, interrupt, reset load target address
// (RULE4) met skip discards prefetched word, dummy cycle
// (RULE5) low byte write jumps within page, dummy
// (RULE6) four level stack, invisible to software
// (RULE7) call/interrupt push pc, exits pop it
// (RULE8) reset leaves stack pointer at empty
// (RULE9) full stack holds interrupt pending, no acknowledge
// (RULE10) call on full stack drops oldest entry
// (RULE11) alu writes destination and updates status
// (RULE12) add, sub, daa, logic, rotate, inc, dec
// (RULE13) program memory 2K x 16, pc or pointer
// (RULE14) execution starts fetching at address zero
// (RULE15) table read: low to data, high latch
// (RULE16) high latch read-only, overwritten by every read
// (RULE17) table read takes two instruction cycles
// (RULE18) full fetch uses both pointers, last page low
// (RULE19) four clock phases form one instruction cycle
// (RULE20) pc changing instructions take one extra cycle
package pss_pkg;
    localparam int PM_DEPTH = 2048;
    localparam int RAM_DEPTH = 64;
    localparam int STACK_DEPTH = 4;
    localparam logic [10:0] RESET_VECTOR = 11'h000;
    localparam logic [10:0] INT_VECTOR = 11'h004;
    localparam logic [10:0] LAST_PAGE_BASE = 11'h700;
    localparam logic [2:0] SP_EMPTY = 3'h0;
    localparam logic [2:0] SP_FULL = 3'h4;
    localparam logic [1:0] PHASE_FIRST = 2'h0;
    localparam logic [1:0] PHASE_LAST = 2'h3;
    // data space locations seen by instructions
    localparam logic [7:0] DA_ACC = 8'h05;
    localparam logic [7:0] DA_PC_LOW = 8'h06;
    localparam logic [7:0] DA_TABLE_PTR_LOW = 8'h07;
    localparam logic [7:0] DA_TABLE_HIGH = 8'h08;
    localparam logic [7:0] DA_TABLE_PTR_HIGH = 8'h09;
    localparam logic [7:0] DA_STATUS = 8'h0a;
    localparam int ST_C = 0;
    localparam int ST_AC = 1;
    localparam int ST_Z = 2;
    localparam int ST_OV = 3;
    localparam int OP_MSB = 15;
    localparam int OP_LSB = 11;
    localparam int DEST_BIT = 8;
    localparam logic [3:0] BCD_MAX = 4'h9;
    localparam logic [8:0] BCD_LOW_FIX = 9'h006;
    localparam logic [8:0] BCD_HIGH_FIX = 9'h060;
    // apb byte offsets
    localparam logic [11:0] REG_CTRL = 12'h000;
    localparam logic [11:0] REG_STATUS = 12'h004;
    localparam logic [11:0] REG_PC_LOW = 12'h008;
    localparam logic [11:0] REG_PC = 12'h00c;
    localparam logic [11:0] REG_ACC = 12'h010;
    localparam logic [11:0] REG_TABLE_HIGH = 12'h014;
    localparam logic [11:0] REG_PM_ADDR = 12'h018;
    localparam logic [11:0] REG_PM_DATA = 12'h01c;
    localparam int CTRL_RUN = 0;
    localparam int CTRL_EMI = 1;
    localparam int STAT_INT_PEND = 4;
    localparam int STAT_EXEC_VALID = 5;
    typedef enum logic [4:0] {
        OP_NOP = 5'b00000, OP_ADD = 5'b00001, OP_ADC = 5'b00010, OP_SUB = 5'b00011,
        OP_SBC = 5'b00100, OP_AND = 5'b00101, OP_OR = 5'b00110, OP_XOR = 5'b00111,
        OP_DAA = 5'b01000, OP_CPL = 5'b01001, OP_RR = 5'b01010, OP_RRC = 5'b01011,
        OP_RL = 5'b01100, OP_RLC = 5'b01101, OP_INC = 5'b01110, OP_DEC = 5'b01111,
        OP_LOAD = 5'b10000, OP_STORE = 5'b10001, OP_LOADI = 5'b10010,
        OP_UNCONDITIONAL_BRANCH = 5'b10011, OP_CALL = 5'b10100,
        OP_SUBROUTINE_EXIT = 5'b10101, OP_INTERRUPT_EXIT = 5'b10110,
        OP_SKIP_ZERO = 5'b10111, OP_SKIP_NONZERO = 5'b11000,
        OP_INC_SKIP_ZERO = 5'b11001, OP_DEC_SKIP_ZERO = 5'b11010,
        OP_FULL_TABLE_FETCH = 5'b11011, OP_LAST_PAGE_TABLE_FETCH = 5'b11100
    } pss_op_t;
endpackage : pss_pkg

// [pss_sequencer.sv]
// program sequencer core: pc, prefetch pipeline, return stack, alu, table reads
// assumes an APB master loads program memory, then sets the run bit
//
// The address map and the APB slave port were left to the implementer.
`timescale 1ns/100ps
module pss_sequencer (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic intReq,
    output logic intAck
);
    import pss_pkg::*;

    logic [15:0] progMem [PM_DEPTH];
    logic [7:0] ram [RAM_DEPTH];
    logic [10:0] retStack [STACK_DEPTH];
    logic run, next_run, next_pready, next_pslverr, wrStrobe, hit, ctrlWr, pcLowWr, pmWe, next_intAck;
    logic [31:0] next_prdata;
    logic [1:0] phase, next_phase;
    logic [10:0] pc, next_pc, execPc, next_execPc, pmAddr, next_pmAddr; // [RULE2]
    logic [15:0] execWord, next_execWord;
    logic execValid, next_execValid, emi, next_emi, intFlag, next_intFlag;
    logic programCounterLowByteReq, next_programCounterLowByteReq;
    logic [2:0] sp, next_sp;
    logic [3:0] flags, next_flags;
    logic [7:0] acc, next_acc, tablePtrLow, next_tablePtrLow, tablePtrHigh, next_tablePtrHigh;
    logic [7:0] tableHighByteLatch, next_tableHighByteLatch, programCounterLowByteVal, next_programCounterLowByteVal;
    pss_op_t op;
    logic [7:0] dataAddr, memVal, opB, res, wrVal, ramWd;
    logic [8:0] sum9, daa9;
    logic [4:0] half5;
    logic cin, wrEn, redirect, skip, stall, pushEn, popEn, ramWe;
    logic [10:0] target, tableAddr, pushVal;
    logic [15:0] tableWord;
    logic [5:0] ramIdx;
    // apb slave: one wait state, effects at the pready edge
    always_comb begin
        next_pready = 1'b0;
        next_pslverr = 1'b0;
        hit = 1'b1;
        unique case (paddr)
            REG_CTRL: next_prdata = {30'h0, emi, run};
            REG_STATUS: next_prdata = {26'h0, execValid, intFlag, flags};
            REG_PC_LOW: next_prdata = {24'h0, execPc[7:0]};
            REG_PC: next_prdata = {21'h0, execPc};
            REG_ACC: next_prdata = {24'h0, acc};
            REG_TABLE_HIGH: next_prdata = {24'h0, tableHighByteLatch};
            REG_PM_ADDR: next_prdata = {21'h0, pmAddr};
            REG_PM_DATA: next_prdata = {16'h0, progMem[pmAddr]};
            default: begin
                next_prdata = 32'h0;
                hit = 1'b0;
            end
        endcase
        if (psel && penable && !pready) begin
            next_pready = 1'b1;
            next_pslverr = !hit;
        end
        if (!psel || !penable || pready || (pwrite && hit)) begin
            next_prdata = prdata;
        end
        wrStrobe = psel && penable && pready && pwrite && !pslverr;
        ctrlWr = wrStrobe && (paddr == REG_CTRL);
        pcLowWr = wrStrobe && (paddr == REG_PC_LOW);
        pmWe = wrStrobe && (paddr == REG_PM_DATA);
        next_run = ctrlWr ? pwdata[CTRL_RUN] : run;
        next_pmAddr = pmWe ? pmAddr + 11'h001 : ((wrStrobe && (paddr == REG_PM_ADDR)) ? pwdata[10:0] : pmAddr);
    end
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            run <= 1'b0;
            pmAddr <= 11'h000;
            prdata <= 32'h0;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            run <= next_run;
            pmAddr <= next_pmAddr;
            prdata <= next_prdata;
            pready <= next_pready;
            pslverr <= next_pslverr;
        end
    end
    // core: everything but the phase count, the intAck clear and the apb and intReq sets commits at the last of the four phases
    always_comb begin
        next_phase = phase;
        next_pc = pc;
        next_execPc = execPc;
        next_execWord = execWord;
        next_execValid = execValid;
        next_sp = sp;
        next_acc = acc;
        next_flags = flags;
        next_tablePtrLow = tablePtrLow;
        next_tablePtrHigh = tablePtrHigh;
        next_tableHighByteLatch = tableHighByteLatch;
        next_emi = emi;
        next_intFlag = intFlag;
        next_programCounterLowByteReq = programCounterLowByteReq;
        next_programCounterLowByteVal = programCounterLowByteVal;
        next_intAck = 1'b0;
        op = pss_op_t'(execWord[OP_MSB:OP_LSB]);
        dataAddr = execWord[7:0];
        unique case (dataAddr)
            DA_ACC: memVal = acc;
            DA_PC_LOW: memVal = execPc[7:0];
            DA_TABLE_PTR_LOW: memVal = tablePtrLow;
            DA_TABLE_HIGH: memVal = tableHighByteLatch;
            DA_TABLE_PTR_HIGH: memVal = tablePtrHigh;
            DA_STATUS: memVal = {4'h0, flags};
            default: memVal = ram[dataAddr[5:0]];
        endcase
        opB = ((op == OP_SUB) || (op == OP_SBC)) ? ~memVal : memVal;
        cin = (op == OP_SUB) || (((op == OP_ADC) || (op == OP_SBC)) && flags[ST_C]);
        sum9 = {1'b0, acc} + {1'b0, opB} + {8'h0, cin};
        half5 = {1'b0, acc[3:0]} + {1'b0, opB[3:0]} + {4'h0, cin};
        daa9 = {1'b0, acc};
        if ((acc[3:0] > BCD_MAX) || flags[ST_AC]) begin
            daa9 = daa9 + BCD_LOW_FIX;
        end
        if ((daa9[7:4] > BCD_MAX) || flags[ST_C] || daa9[8]) begin
            daa9 = {1'b0, daa9[7:0]} + BCD_HIGH_FIX + {daa9[8], 8'h0};
        end
        tableAddr = (op == OP_LAST_PAGE_TABLE_FETCH) ? (LAST_PAGE_BASE | {3'h0, tablePtrLow})
            : {tablePtrHigh[2:0], tablePtrLow}; // [RULE18]
        tableWord = progMem[tableAddr]; // [RULE13]
        res = 8'h0;
        wrVal = 8'h0;
        wrEn = 1'b0;
        redirect = 1'b0;
        skip = 1'b0;
        stall = 1'b0;
        target = pc;
        pushEn = 1'b0;
        popEn = 1'b0;
        pushVal = pc;
        ramWe = 1'b0;
        ramIdx = dataAddr[5:0];
        ramWd = 8'h0;
        if (run) begin
            next_phase = phase + 2'h1; // [RULE19]
        end
        if (run && (phase == PHASE_LAST) && execValid) begin
            unique case (op)
                OP_ADD, OP_ADC, OP_SUB, OP_SBC: begin // [RULE12]
                    res = sum9[7:0];
                    next_flags[ST_C] = sum9[8]; // [RULE11]
                    next_flags[ST_AC] = half5[4];
                    next_flags[ST_Z] = (sum9[7:0] == 8'h0);
                    next_flags[ST_OV] = (acc[7] == opB[7]) && (sum9[7] != acc[7]);
                end
                OP_AND, OP_OR, OP_XOR, OP_CPL, OP_INC, OP_DEC: begin
                    unique case (op)
                        OP_AND: res = acc & memVal;
                        OP_OR: res = acc | memVal;
                        OP_XOR: res = acc ^ memVal;
                        OP_CPL: res = ~memVal;
                        OP_INC: res = memVal + 8'h01;
                        default: res = memVal - 8'h01;
                    endcase
                    next_flags[ST_Z] = (res == 8'h0); // [RULE11]
                end
                OP_RR: res = {memVal[0], memVal[7:1]};
                OP_RL: res = {memVal[6:0], memVal[7]};
                OP_RRC: begin
                    res = {flags[ST_C], memVal[7:1]};
                    next_flags[ST_C] = memVal[0];
                end
                OP_RLC: begin
                    res = {memVal[6:0], flags[ST_C]};
                    next_flags[ST_C] = memVal[7];
                end
                OP_DAA: begin
                    wrEn = 1'b1;
                    wrVal = daa9[7:0];
                    next_flags[ST_C] = flags[ST_C] | daa9[8]; // [RULE11]
                end
                OP_LOAD: next_acc = memVal;
                OP_STORE: begin
                    wrEn = 1'b1;
                    wrVal = acc;
                end
                OP_LOADI: next_acc = execWord[7:0];
                OP_UNCONDITIONAL_BRANCH: begin
                    redirect = 1'b1;
                    target = execWord[10:0]; // [RULE3]
                end
                OP_CALL: begin
                    redirect = 1'b1;
                    target = execWord[10:0]; // [RULE3]
                    pushEn = 1'b1; // [RULE7] [RULE10]
                end
                OP_SUBROUTINE_EXIT, OP_INTERRUPT_EXIT: begin
                    redirect = 1'b1;
                    popEn = 1'b1; // [RULE7]
                    target = (sp == SP_EMPTY) ? retStack[0] : retStack[2'(sp - 3'h1)];
                    if (op == OP_INTERRUPT_EXIT) begin
                        next_emi = 1'b1;
                    end
                end
                OP_SKIP_ZERO: skip = (memVal == 8'h0); // [RULE4]
                OP_SKIP_NONZERO: skip = (memVal != 8'h0); // [RULE4]
                OP_INC_SKIP_ZERO, OP_DEC_SKIP_ZERO: begin
                    wrEn = 1'b1;
                    wrVal = (op == OP_INC_SKIP_ZERO) ? memVal + 8'h01 : memVal - 8'h01;
                    skip = (wrVal == 8'h0); // [RULE4]
                end
                OP_FULL_TABLE_FETCH, OP_LAST_PAGE_TABLE_FETCH: begin
                    wrEn = 1'b1;
                    wrVal = tableWord[7:0]; // [RULE15]
                    next_tableHighByteLatch = tableWord[15:8]; // [RULE15] [RULE16]
                    stall = 1'b1; // [RULE17]
                end
                default: res = 8'h0;
            endcase
            // accumulator ops target memory with the bit set, unary ops the reverse
            if ((op >= OP_ADD) && (op <= OP_XOR)) begin
                if (execWord[DEST_BIT]) begin
                    wrEn = 1'b1;
                    wrVal = res;
                end else begin
                    next_acc = res; // [RULE11]
                end
            end else if ((op >= OP_CPL) && (op <= OP_DEC)) begin
                if (execWord[DEST_BIT]) begin
                    next_acc = res; // [RULE11]
                end else begin
                    wrEn = 1'b1;
                    wrVal = res;
                end
            end
            if (wrEn) begin
                unique case (dataAddr)
                    DA_ACC: next_acc = wrVal;
                    DA_PC_LOW: begin
                        redirect = 1'b1;
                        target = {execPc[10:8], wrVal}; // [RULE5]
                    end
                    DA_TABLE_PTR_LOW: next_tablePtrLow = wrVal;
                    DA_TABLE_HIGH: next_tableHighByteLatch = next_tableHighByteLatch; // [RULE16]
                    DA_TABLE_PTR_HIGH: next_tablePtrHigh = wrVal;
                    DA_STATUS: next_flags = wrVal[3:0];
                    default: begin
                        ramWe = 1'b1;
                        ramWd = wrVal;
                    end
                endcase
            end
        end
        if (run && (phase == PHASE_LAST)) begin
            if (programCounterLowByteReq && !redirect) begin
                redirect = 1'b1;
                target = {pc[10:8], programCounterLowByteVal}; // [RULE5]
                next_programCounterLowByteReq = 1'b0;
            end
            // full stack keeps the request pending until a return frees a level
            if (!redirect && !skip && !stall && intFlag && emi && (sp != SP_FULL)) begin // [RULE9]
                redirect = 1'b1;
                target = INT_VECTOR; // [RULE3]
                pushEn = 1'b1; // [RULE7]
                next_emi = 1'b0;
                next_intFlag = 1'b0;
                next_intAck = 1'b1;
            end
            if (pushEn) begin
                next_sp = (sp == SP_FULL) ? sp : sp + 3'h1; // [RULE10]
            end else if (popEn && (sp != SP_EMPTY)) begin
                next_sp = sp - 3'h1;
            end
            // a flushed slot is the extra cycle paid by every redirect
            if (redirect) begin
                next_pc = target; // [RULE3]
                next_execValid = 1'b0; // [RULE20]
            end else if (stall) begin
                next_execValid = 1'b0; // [RULE17]
            end else if (skip) begin
                next_pc = pc + 11'h001; // [RULE4]
                next_execValid = 1'b0;
            end else begin
                next_execWord = progMem[pc];
                next_execPc = pc;
                next_execValid = 1'b1;
                next_pc = pc + 11'h001; // [RULE1]
            end
        end
        // late sets win over the clears above
        if (ctrlWr) begin
            next_emi = pwdata[CTRL_EMI];
        end
        if (intReq) begin
            next_intFlag = 1'b1; // [RULE9]
        end
        if (pcLowWr) begin
            next_programCounterLowByteReq = 1'b1;
            next_programCounterLowByteVal = pwdata[7:0];
        end
    end
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            phase <= PHASE_FIRST;
            pc <= RESET_VECTOR; // [RULE14]
            execPc <= RESET_VECTOR;
            execWord <= 16'h0;
            execValid <= 1'b0;
            sp <= SP_EMPTY; // [RULE8]
            acc <= 8'h0;
            flags <= 4'h0;
            tablePtrLow <= 8'h0;
            tablePtrHigh <= 8'h0;
            tableHighByteLatch <= 8'h0;
            emi <= 1'b0;
            intFlag <= 1'b0;
            programCounterLowByteReq <= 1'b0;
            programCounterLowByteVal <= 8'h0;
            intAck <= 1'b0;
        end else begin
            phase <= next_phase;
            pc <= next_pc;
            execPc <= next_execPc;
            execWord <= next_execWord;
            execValid <= next_execValid;
            sp <= next_sp;
            acc <= next_acc;
            flags <= next_flags;
            tablePtrLow <= next_tablePtrLow;
            tablePtrHigh <= next_tablePtrHigh;
            tableHighByteLatch <= next_tableHighByteLatch;
            emi <= next_emi;
            intFlag <= next_intFlag;
            programCounterLowByteReq <= next_programCounterLowByteReq;
            programCounterLowByteVal <= next_programCounterLowByteVal;
            intAck <= next_intAck;
        end
    end
    // return stack has no software path at all; program memory only the loader port and the table fetch instructions
    always_ff @(posedge clk) begin
        if (pmWe) begin
            progMem[pmAddr] <= pwdata[15:0]; // [RULE13]
        end
        if (pushEn) begin
            if (sp == SP_FULL) begin
                for (int i = 0; i < STACK_DEPTH - 1; i++) begin
                    retStack[i] <= retStack[i + 1]; // [RULE10]
                end
                retStack[STACK_DEPTH - 1] <= pushVal;
            end else begin
                retStack[sp[1:0]] <= pushVal; // [RULE6] [RULE7]
            end
        end
        if (ramWe) begin
            ram[ramIdx] <= ramWd;
        end
    end
endmodule : pss_sequencer

// [pss_sequencer_checker.sv]
// concurrent checks on the sequencer's apb and interrupt ports
// bound to every pss_sequencer instance and sees its ports only
`timescale 1ns/100ps
module pss_sequencer_checker (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic intReq,
    input wire logic intAck
);
    logic reqSeen;
    logic next_reqSeen;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);
    // sticky since reset, so an acknowledge always has a cause
    always_comb begin
        next_reqSeen = reqSeen | intReq;
    end
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            reqSeen <= 1'b0;
        end else begin
            reqSeen <= next_reqSeen;
        end
    end
    AST_ONE_WAIT: assert property (psel && penable && !pready |=> pready)
        else $error("no answer after first access cycle");
    AST_READY_PULSE: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    AST_READY_IN_ACCESS: assert property (pready |-> psel && penable && $past(psel && penable))
        else $error("pready outside an access phase");
    AST_ERR_ZERO: assert property (pslverr |-> pready && prdata == 32'h0)
        else $error("error answer without zero data");
    AST_RDATA_HOLD: assert property ($changed(prdata) |-> pready && (!pwrite || pslverr))
        else $error("read data moved outside a read answer");
    AST_ACK_SPACING: assert property (intAck |=> !intAck [*3])
        else $error("acknowledges closer than one instruction cycle");
    AST_ACK_AFTER_RESET: assert property ($rose(rst_n) |-> !intAck [*4])
        else $error("acknowledge right after reset");
    AST_ACK_CAUSE: assert property (intAck |-> reqSeen)
        else $error("acknowledge without any request");
    cover property (psel && penable && pready && pwrite);
    cover property (pready && pslverr);
    cover property (intAck);
endmodule : pss_sequencer_checker

bind pss_sequencer pss_sequencer_checker chk (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .intReq(intReq), .intAck(intAck));

// [tb_top.sv]
// self-checking bench: apb loads programs, runs the core, reads results
// assumes pss_sequencer with its checker bound in
`timescale 1ns/100ps
module tb_top;
    import pss_pkg::*;
    localparam pss_op_t BR = OP_UNCONDITIONAL_BRANCH;
    localparam pss_op_t LEAVE = OP_SUBROUTINE_EXIT;
    logic clk;
    logic rst_n;
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic intReq;
    logic intAck;
    int miscompares;
    int total_checks;
    int ackCount;
    logic [31:0] rd;
    logic err;
    pss_op_t aluOp [15];
    logic [7:0] aluExp [15];
    logic [1:0] aluC [15];
    logic [26:0] prog [43];

    pss_sequencer uut (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .intReq(intReq), .intAck(intAck));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    always @(posedge clk) begin
        if (intAck === 1'b1) begin
            ackCount++;
        end
    end

    function automatic logic [15:0] iw(pss_op_t o, logic [10:0] x);
        return {o, x};
    endfunction : iw

    task automatic chk(string name, logic [31:0] seen, logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk

    // entered just after a rising edge; leaves one idle cycle behind it
    task automatic apb(logic wr, logic [11:0] a, logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1 && n < 20) begin
            n++;
            @(posedge clk);
        end
        chk("pready", {31'h0, pready}, 32'h1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask : apb

    task automatic do_reset();
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
    endtask : do_reset

    task automatic load(int n);
        for (int i = 0; i < n; i++) begin
            apb(1'b1, REG_PM_ADDR, {21'h0, prog[i][26:16]});
            apb(1'b1, REG_PM_DATA, {16'h0, prog[i][15:0]});
        end
    endtask : load

    task automatic stop_test();
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : stop_test

    initial begin
        repeat (20000) @(posedge clk);
        miscompares++;
        stop_test();
    end

    initial begin
        rst_n = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        intReq = 1'b0;
        miscompares = 0;
        total_checks = 0;
        ackCount = 0;
        aluOp = '{OP_ADD, OP_ADC, OP_SUB, OP_SBC, OP_AND, OP_OR, OP_XOR, OP_DAA,
            OP_CPL, OP_RR, OP_RRC, OP_RL, OP_RLC, OP_INC, OP_DEC};
        aluExp = '{8'hde, 8'hdf, 8'h56, 8'h56, 8'h00, 8'hde, 8'hde, 8'h00,
            8'hbb, 8'h22, 8'ha2, 8'h88, 8'h89, 8'h45, 8'h43};
        aluC = '{2'b10, 2'b10, 2'b11, 2'b11, 2'b00, 2'b00, 2'b00, 2'b11,
            2'b00, 2'b00, 2'b10, 2'b00, 2'b10, 2'b00, 2'b00};
        @(posedge clk);
        do_reset();
        apb(1'b0, REG_PC, 32'h0);
        chk("pc after reset", rd, 32'h0);
        apb(1'b0, 12'h020, 32'h0);
        chk("unmapped", {rd[30:0], err}, 32'h1);
        // subtracting m from itself leaves carry set before each operation
        prog[0] = {11'h000, iw(OP_LOADI, 11'h044)};
        prog[1] = {11'h001, iw(OP_STORE, 11'h010)};
        prog[2] = {11'h002, iw(OP_SUB, 11'h010)};
        prog[3] = {11'h003, iw(OP_LOADI, 11'h09a)};
        prog[5] = {11'h005, iw(OP_LOAD, 11'h010)};
        prog[6] = {11'h006, iw(BR, 11'h006)};
        for (int i = 0; i < 15; i++) begin
            prog[4] = {11'h004, iw(aluOp[i], {2'b00, aluOp[i] <= OP_XOR, 8'h10})};
            do_reset();
            load(7);
            apb(1'b1, REG_CTRL, 32'h1);
            repeat (80) @(posedge clk);
            apb(1'b0, REG_ACC, 32'h0);
            chk("alu result", rd, {24'h0, aluExp[i]});
            if (aluC[i][1]) begin
                apb(1'b0, REG_STATUS, 32'h0);
                chk("carry", {31'h0, rd[ST_C]}, {31'h0, aluC[i][0]});
            end
        end
        $display("test alu done");
        // wrong paths land in the trap at 003; a fifth call overflows the stack
        prog = '{{11'h000, iw(OP_LOADI, 11'h000)}, {11'h001, iw(OP_STORE, 11'h012)}, {11'h002, iw(OP_CALL, 11'h010)},
            {11'h003, iw(BR, 11'h003)}, {11'h004, iw(OP_INC, 11'h016)}, {11'h005, iw(OP_INTERRUPT_EXIT, 11'h000)},
            {11'h010, iw(OP_CALL, 11'h020)}, {11'h011, iw(OP_LOADI, 11'h05a)}, {11'h012, iw(OP_STORE, 11'h013)},
            {11'h013, iw(OP_SKIP_ZERO, 11'h013)}, {11'h014, iw(OP_SKIP_NONZERO, 11'h013)}, {11'h015, iw(BR, 11'h003)},
            {11'h016, iw(OP_LOADI, 11'h050)}, {11'h017, iw(OP_STORE, 11'h006)}, {11'h018, iw(BR, 11'h003)},
            {11'h020, iw(OP_CALL, 11'h030)}, {11'h021, iw(LEAVE, 11'h000)}, {11'h030, iw(OP_CALL, 11'h038)},
            {11'h031, iw(LEAVE, 11'h000)}, {11'h038, iw(OP_CALL, 11'h03c)}, {11'h039, iw(OP_INC_SKIP_ZERO, 11'h012)},
            {11'h03a, iw(LEAVE, 11'h000)}, {11'h03c, iw(BR, 11'h03c)}, {11'h03d, iw(OP_INC, 11'h012)},
            {11'h03e, iw(LEAVE, 11'h000)}, {11'h050, iw(OP_LOADI, 11'h006)}, {11'h051, iw(OP_STORE, 11'h007)},
            {11'h052, iw(OP_LOADI, 11'h002)}, {11'h053, iw(OP_STORE, 11'h009)}, {11'h054, iw(OP_FULL_TABLE_FETCH, 11'h014)},
            {11'h055, iw(OP_LOADI, 11'h005)}, {11'h056, iw(OP_STORE, 11'h007)},
            {11'h057, iw(OP_LAST_PAGE_TABLE_FETCH, 11'h015)}, {11'h058, iw(OP_LOAD, 11'h014)},
            {11'h059, iw(OP_ADD, 11'h015)}, {11'h05a, iw(OP_ADD, 11'h012)}, {11'h05b, iw(BR, 11'h05b)},
            {11'h060, iw(OP_LOADI, 11'h077)}, {11'h061, iw(BR, 11'h061)}, {11'h205, 16'h7777},
            {11'h206, 16'h3c1a}, {11'h705, 16'h0f21}, {11'h706, 16'h5555}};
        do_reset();
        load(43);
        apb(1'b1, REG_CTRL, 32'h1);
        repeat (300) @(posedge clk);
        intReq <= 1'b1;
        @(posedge clk);
        intReq <= 1'b0;
        apb(1'b1, REG_CTRL, 32'h3);
        repeat (200) @(posedge clk);
        apb(1'b0, REG_STATUS, 32'h0);
        chk("pending", {31'h0, rd[STAT_INT_PEND]}, 32'h1);
        chk("acks while full", 32'(ackCount), 32'h0);
        apb(1'b1, REG_PC_LOW, 32'h3d);
        repeat (400) @(posedge clk);
        chk("acks after return", 32'(ackCount), 32'h1);
        apb(1'b1, REG_TABLE_HIGH, 32'hff);
        apb(1'b0, REG_TABLE_HIGH, 32'h0);
        chk("table high", rd, 32'h0f);
        apb(1'b0, REG_ACC, 32'h0);
        chk("flow result", rd, 32'h3d);
        apb(1'b1, REG_PC_LOW, 32'h60);
        repeat (60) @(posedge clk);
        apb(1'b0, REG_ACC, 32'h0);
        chk("page jump", rd, 32'h77);
        apb(1'b0, REG_PC_LOW, 32'h0);
        chk("pc low", rd, 32'h61);
        $display("test flow done");
        stop_test();
    end
endmodule : tb_top
